// ---- fnd_ref_divider.sv ----
// Purpose: Shared constants and the programmable reference divider.
// Assumes: Reference edges arrive as one-cycle ticks on sys_clk.
// Notes: Package first, so this file compiles before the top.
package fnd_pkg;
	// Register map, byte addresses
	localparam logic [7:0] FND_REG_REF_DIV = 8'h00;
	localparam logic [7:0] FND_REG_FB_INT = 8'h04;
	localparam logic [7:0] FND_REG_FB_FRAC = 8'h08;
	localparam logic [7:0] FND_REG_STATUS = 8'h0c;
	// Field widths and positions
	localparam int FND_REF_W = 15;
	localparam int FND_SWL_W = 5;
	localparam int FND_MAIN_W = 10;
	localparam int FND_NUM_W = 4;
	localparam int FND_MAIN_LSB = 5;
	localparam int FND_PSEL_BIT = 16;
	localparam int FND_MSEL_BIT = 4;
	localparam int FND_ST_ACC_LSB = 16;
	localparam int FND_ST_EXTRA_BIT = 20;
	localparam int FND_ST_CNT_LSB = 24;
	// Reset values: ratio 3, integer ratio 16*17+0
	localparam logic [14:0] FND_REF_RST = 15'h0003;
	localparam logic [14:0] FND_REF_MIN = 15'h0003;
	localparam logic [4:0] FND_SWL_RST = 5'h00;
	localparam logic [9:0] FND_MAIN_RST = 10'h011;
	// Moduli
	localparam logic [5:0] FND_PRE_LO = 6'h10;
	localparam logic [5:0] FND_PRE_HI = 6'h20;
	localparam logic [4:0] FND_FRAC_16 = 5'h10;
	localparam logic [4:0] FND_FRAC_15 = 5'h0f;

	function automatic logic [5:0] fnd_base_mod(input logic psel);
		fnd_base_mod = psel ? FND_PRE_HI : FND_PRE_LO;
	endfunction

	function automatic logic [4:0] fnd_frac_mod(input logic msel);
		fnd_frac_mod = msel ? FND_FRAC_15 : FND_FRAC_16;
	endfunction

	// Integer ratio base*main+swallow, with main>=1 and swallow<=main
	function automatic logic [15:0] fnd_ratio(input logic psel, input logic [4:0] a, input logic [9:0] b);
		logic [9:0] be;
		logic [4:0] ae;
		be = (b == 10'h000) ? 10'h001 : b;
		ae = ({5'h00, a} > be) ? be[4:0] : a;
		fnd_ratio = 16'(fnd_base_mod(psel)) * 16'(be) + 16'(ae);
	endfunction
endpackage

`timescale 1ns/1ps
module fnd_ref_divider
	import fnd_pkg::*;
#(
	parameter int W = FND_REF_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Count input and ratio
	input wire logic tick,
	input wire logic [W-1:0] ratio,
	// Divided output
	output logic pulse_q,
	output logic [W-1:0] cnt_q
);
	logic [W-1:0] eff;
	logic wrap;

	// Ratios below the minimum run at the minimum
	assign eff = (ratio < W'(FND_REF_MIN)) ? W'(FND_REF_MIN) : ratio;
	// >= rather than == so a lowered ratio cannot strand the count
	assign wrap = (cnt_q >= eff - W'(1));

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
		end else if (tick) begin
			cnt_q <= wrap ? '0 : cnt_q + W'(1);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= tick & wrap;
		end
	end

	a_ref_wrap_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
		pulse_q |-> $past(tick) && $past(cnt_q) >= $past(eff) - W'(1))
		else $error("reference pulse without wrap");
	a_ref_tick_only: assert property (@(posedge sys_clk) disable iff (!rstn)
		!tick |=> !pulse_q && $stable(cnt_q))
		else $error("reference divider moved without a tick");
endmodule

// ---- fnd_divider_chain.sv ----
// Purpose: Reference and fractional feedback divider chain of a synthesizer.
// Assumes: Both divider inputs are synchronous levels on sys_clk.
// Notes: Input edge rate is limited to half of sys_clk.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module fnd_divider_chain
	import fnd_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Divider inputs
	input wire logic reference_clock_input,
	input wire logic rf_divider_input,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	// Phase detector pulses
	output logic reference_compare_pulse,
	output logic feedback_compare_pulse
);
	// Input edge detect
	logic ref_prev_q;
	logic rf_prev_q;
	logic ref_tick;
	logic rf_edge;

	// Software settings
	logic [14:0] ref_ratio_q;
	logic [4:0] swl_q;
	logic [9:0] main_q;
	logic psel_q;
	logic [3:0] num_q;
	logic msel_q;

	// Settings in use, taken at each division end
	logic [4:0] sh_a_q;
	logic [9:0] sh_b_q;
	logic sh_psel_q;
	logic [3:0] sh_num_q;
	logic sh_msel_q;

	// Feedback counters
	logic [5:0] pre_cnt_q;
	logic [4:0] a_cnt_q;
	logic [9:0] b_cnt_q;
	logic extra_q;
	logic [3:0] acc_q;
	logic [7:0] fb_cnt_q;
	logic ref_pulse;

	// Decode of the settings in use
	logic [5:0] base;
	logic [9:0] b_eff;
	logic [4:0] a_eff;
	logic swallow_on;
	logic last_period;
	logic [5:0] cur_mod;
	logic period_end;
	logic div_end;
	logic [4:0] acc_sum;
	logic [4:0] frac_mod;
	logic ovf;
	logic [4:0] acc_wrap;
	logic [15:0] ratio_now;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ref_prev_q <= 1'b0;
			rf_prev_q <= 1'b0;
		end else begin
			ref_prev_q <= reference_clock_input;
			rf_prev_q <= rf_divider_input;
		end
	end

	assign ref_tick = reference_clock_input & ~ref_prev_q;
	assign rf_edge = rf_divider_input & ~rf_prev_q;

	// Register writes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ref_ratio_q <= FND_REF_RST;
			swl_q <= FND_SWL_RST;
			main_q <= FND_MAIN_RST;
			psel_q <= 1'b0;
			num_q <= 4'h0;
			msel_q <= 1'b0;
		end else if (wr_en) begin
			case (addr)
				FND_REG_REF_DIV: begin
					ref_ratio_q <= wr_data[FND_REF_W-1:0];
				end
				FND_REG_FB_INT: begin
					swl_q <= wr_data[FND_SWL_W-1:0];
					main_q <= wr_data[FND_MAIN_LSB +: FND_MAIN_W];
					psel_q <= wr_data[FND_PSEL_BIT];
				end
				FND_REG_FB_FRAC: begin
					num_q <= wr_data[FND_NUM_W-1:0];
					msel_q <= wr_data[FND_MSEL_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Reference divider
	fnd_ref_divider #(
		.W(FND_REF_W)
	) u_ref (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.tick(ref_tick),
		.ratio(ref_ratio_q),
		.pulse_q(ref_pulse),
		.cnt_q()
	);

	// Output registers; the reference pulse lands two cycles after its edge, the feedback pulse one
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reference_compare_pulse <= 1'b0;
		end else begin
			reference_compare_pulse <= ref_pulse;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			feedback_compare_pulse <= 1'b0;
		end else begin
			feedback_compare_pulse <= div_end;
		end
	end

	// Decode; out-of-range swallow is clamped to main
	assign base = fnd_base_mod(sh_psel_q);
	assign b_eff = (sh_b_q == 10'h000) ? 10'h001 : sh_b_q;
	assign a_eff = ({5'h00, sh_a_q} > b_eff) ? b_eff[4:0] : sh_a_q;
	assign swallow_on = (a_cnt_q < a_eff);
	assign last_period = (b_cnt_q == b_eff - 10'h001);
	// Pending overflow stretches the last prescaler period by one
	assign cur_mod = base + {5'h00, swallow_on} + {5'h00, last_period & extra_q};
	assign period_end = rf_edge && (pre_cnt_q >= cur_mod - 6'h01);
	assign div_end = period_end && last_period;

	// Fraction accumulator decode
	assign frac_mod = fnd_frac_mod(sh_msel_q);
	assign acc_sum = {1'b0, acc_q} + {1'b0, sh_num_q};
	assign ovf = (acc_sum >= frac_mod);
	assign acc_wrap = ovf ? acc_sum - frac_mod : acc_sum;
	assign ratio_now = fnd_ratio(sh_psel_q, sh_a_q, sh_b_q);

	// Prescaler, clocked only by RF edges
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pre_cnt_q <= 6'h00;
		end else if (rf_edge) begin
			pre_cnt_q <= period_end ? 6'h00 : pre_cnt_q + 6'h01;
		end
	end

	// Swallow counter
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			a_cnt_q <= 5'h00;
		end else if (div_end) begin
			a_cnt_q <= 5'h00;
		end else if (period_end && swallow_on) begin
			a_cnt_q <= a_cnt_q + 5'h01;
		end
	end

	// Main counter
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			b_cnt_q <= 10'h000;
		end else if (div_end) begin
			b_cnt_q <= 10'h000;
		end else if (period_end) begin
			b_cnt_q <= b_cnt_q + 10'h001;
		end
	end

	// Accumulator steps once per comparison cycle
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			acc_q <= 4'h0;
			extra_q <= 1'b0;
		end else if (div_end) begin
			acc_q <= acc_wrap[3:0];
			extra_q <= ovf;
		end
	end

	// New feedback settings only at a division boundary, so no cycle is torn; the reference ratio applies at once
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sh_a_q <= FND_SWL_RST;
			sh_b_q <= FND_MAIN_RST;
			sh_psel_q <= 1'b0;
			sh_num_q <= 4'h0;
			sh_msel_q <= 1'b0;
		end else if (div_end) begin
			sh_a_q <= swl_q;
			sh_b_q <= main_q;
			sh_psel_q <= psel_q;
			sh_num_q <= num_q;
			sh_msel_q <= msel_q;
		end
	end

	// Feedback pulse count for status
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fb_cnt_q <= 8'h00;
		end else if (div_end) begin
			fb_cnt_q <= fb_cnt_q + 8'h01;
		end
	end

	// Register reads, data in the following cycle only
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data <= 32'h0000_0000;
		end else begin
			rd_data <= 32'h0000_0000;
			if (rd_en) begin
				case (addr)
					FND_REG_REF_DIV: begin
						rd_data <= {17'h00000, ref_ratio_q};
					end
					FND_REG_FB_INT: begin
						rd_data <= {15'h0000, psel_q, 1'b0, main_q, swl_q};
					end
					FND_REG_FB_FRAC: begin
						rd_data <= {27'h0000000, msel_q, num_q};
					end
					FND_REG_STATUS: begin
						rd_data <= {fb_cnt_q, 3'h0, extra_q, acc_q, ratio_now};
					end
					default: begin
						rd_data <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// Checker helpers: RF edges per division and the length expected
	logic [15:0] len_q;
	logic [15:0] exp_q;
	logic [15:0] exp_d;

	assign exp_d = fnd_ratio(psel_q, swl_q, main_q) + {15'h0000, ovf};

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			len_q <= 16'h0000;
		end else if (div_end) begin
			len_q <= 16'h0000;
		end else if (rf_edge) begin
			len_q <= len_q + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			exp_q <= fnd_ratio(1'b0, FND_SWL_RST, FND_MAIN_RST);
		end else if (div_end) begin
			exp_q <= exp_d;
		end
	end

	a_fb_div_length: assert property (@(posedge sys_clk) disable iff (!rstn)
		div_end |-> (len_q + 16'h0001) == exp_q)
		else $error("feedback division length wrong");

	a_fb_rf_clocked: assert property (@(posedge sys_clk) disable iff (!rstn)
		feedback_compare_pulse |-> $past(rf_edge) && !$past(ref_tick && !rf_edge))
		else $error("feedback pulse without an RF edge");

	a_fb_pulse_single: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(feedback_compare_pulse) |=> !feedback_compare_pulse ##1 !feedback_compare_pulse)
		else $error("feedback pulse longer than one cycle");

	a_acc_in_range: assert property (@(posedge sys_clk) disable iff (!rstn)
		div_end && {1'b0, acc_q} < frac_mod |=> {1'b0, acc_q} < $past(frac_mod))
		else $error("accumulator beyond its modulus");

	a_acc_ovf_extra: assert property (@(posedge sys_clk) disable iff (!rstn)
		div_end && ({1'b0, acc_q} + {1'b0, sh_num_q} >= frac_mod) |=> extra_q && cur_mod >= base)
		else $error("overflow did not arm a swallow");

	a_acc_step: assert property (@(posedge sys_clk) disable iff (!rstn)
		div_end && !ovf |=> acc_q == $past(acc_q) + $past(sh_num_q))
		else $error("accumulator did not add the numerator");

	a_swallow_limit: assert property (@(posedge sys_clk) disable iff (!rstn)
		{5'h00, a_cnt_q} <= b_eff)
		else $error("swallow count passed main count");

	a_prescale_mod: assert property (@(posedge sys_clk) disable iff (!rstn)
		pre_cnt_q < cur_mod && (base == FND_PRE_LO || base == FND_PRE_HI))
		else $error("prescaler count out of range");

	a_main_limit: assert property (@(posedge sys_clk) disable iff (!rstn)
		b_cnt_q < b_eff)
		else $error("main count passed its setting");

	// Range checks on measured lengths, not on the decode
	a_lo_ratio_span: assert property (@(posedge sys_clk) disable iff (!rstn)
		div_end && !sh_psel_q && sh_b_q >= 10'h011 |->
		(len_q + 16'h0001) >= 16'h0110 && (len_q + 16'h0001) <= 16'h4010)
		else $error("16/17 division outside its range");

	a_hi_ratio_span: assert property (@(posedge sys_clk) disable iff (!rstn)
		div_end && sh_psel_q && sh_b_q >= 10'h021 |->
		(len_q + 16'h0001) >= 16'h0420 && (len_q + 16'h0001) <= 16'h8000)
		else $error("32/33 division outside its range");

endmodule

// ---- fnd_osc_model.sv ----
// Purpose: Reference oscillator and VCO seen from the divider chain.
// Assumes: Levels change just after a rising sys_clk edge.
// Notes: Stopped or in reset, both lines sit low so no false edge is counted.
`timescale 1ns/1ps
module fnd_osc_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Run controls, half period in sys_clk cycles
	input wire logic ref_run,
	input wire logic rf_run,
	input wire logic [3:0] ref_half,
	input wire logic [3:0] rf_half,
	// Oscillator levels
	output logic reference_clock_input,
	output logic rf_divider_input
);
	logic [3:0] ref_cnt_q;
	logic [3:0] rf_cnt_q;

	// Reference oscillator, slow or fast by half period
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ref_cnt_q <= 4'h0;
			reference_clock_input <= 1'b0;
		end else if (!ref_run) begin
			ref_cnt_q <= 4'h0;
			reference_clock_input <= 1'b0;
		end else if (ref_cnt_q + 4'h1 >= ref_half) begin
			ref_cnt_q <= 4'h0;
			reference_clock_input <= ~reference_clock_input;
		end else begin
			ref_cnt_q <= ref_cnt_q + 4'h1;
		end
	end

	// VCO output, counted only by the feedback side
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rf_cnt_q <= 4'h0;
			rf_divider_input <= 1'b0;
		end else if (!rf_run) begin
			rf_cnt_q <= 4'h0;
			rf_divider_input <= 1'b0;
		end else if (rf_cnt_q + 4'h1 >= rf_half) begin
			rf_cnt_q <= 4'h0;
			rf_divider_input <= ~rf_divider_input;
		end else begin
			rf_cnt_q <= rf_cnt_q + 4'h1;
		end
	end
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the divider chain.
// Assumes: VCO edge every 2 cycles, reference edge every 4 cycles.
// Notes: Pulse spacing in sys_clk cycles stands in for division ratios.
`timescale 1ns/1ps
module tb_top
	import fnd_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic ref_run = 1'b0;
	logic rf_run = 1'b0;
	logic reference_clock_input;
	logic rf_divider_input;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] rd_data;
	logic reference_compare_pulse;
	logic feedback_compare_pulse;
	int num_errors = 0;
	int n_tests = 0;

	always #12.5 sys_clk = ~sys_clk;

	fnd_osc_model fnd_osc_model_i (.sys_clk(sys_clk), .rstn(rstn), .ref_run(ref_run), .rf_run(rf_run),
		.ref_half(4'h2), .rf_half(4'h1), .reference_clock_input(reference_clock_input),
		.rf_divider_input(rf_divider_input));

	fnd_divider_chain fnd_divider_chain_i (.sys_clk(sys_clk), .rstn(rstn),
		.reference_clock_input(reference_clock_input), .rf_divider_input(rf_divider_input),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.reference_compare_pulse(reference_compare_pulse), .feedback_compare_pulse(feedback_compare_pulse));

	task automatic finish_test();
		$display("errors=%0d checks=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask

	// Data stands only in the cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		@(negedge sys_clk);
		d = rd_data;
	endtask

	// Cycles spanned by n divisions; exp 0 only skips boundaries
	task automatic span(input bit fb, input int n, input int exp);
		int c;
		int t;
		c = 0;
		for (int k = 0; k <= n; k++) begin
			t = 0;
			do begin
				@(negedge sys_clk);
				t++;
				if (k > 0)
					c++;
				if (t > 6000) begin
					num_errors++;
					finish_test();
				end
			end while ((fb ? feedback_compare_pulse : reference_compare_pulse) !== 1'b1);
		end
		if (exp > 0)
			chk(32'(c), 32'(exp));
	endtask

	task automatic t_reset();
		logic [31:0] d;
		rd(FND_REG_REF_DIV, d);
		chk(d, 32'h0000_0003);
		rd(FND_REG_FB_INT, d);
		chk(d, 32'h0000_0220);
		rd(FND_REG_FB_FRAC, d);
		chk(d, 32'h0000_0000);
		rd(FND_REG_STATUS, d);
		chk(d, 32'h0000_0110);
		rd(8'h10, d);
		chk(d, 32'h0000_0000);
	endtask

	task automatic t_refdiv();
		logic [31:0] d;
		wr(FND_REG_REF_DIV, 32'h0000_ffff);
		rd(FND_REG_REF_DIV, d);
		chk(d, 32'h0000_7fff);
		wr(FND_REG_REF_DIV, 32'h0000_0005);
		ref_run <= 1'b1;
		span(1'b0, 2, 0);
		span(1'b0, 2, 40);
		wr(FND_REG_REF_DIV, 32'h0000_0003);
		span(1'b0, 2, 0);
		span(1'b0, 3, 36);
		wr(FND_REG_REF_DIV, 32'h0000_0001);
		span(1'b0, 2, 0);
		span(1'b0, 2, 24);
	endtask

	// Prescaler, main and swallow boundaries, reference still running
	task automatic t_fbint();
		logic [31:0] d;
		int cfg [4][4] = '{'{0, 17, 0, 272}, '{0, 20, 20, 340}, '{1, 33, 0, 1056}, '{1, 40, 7, 1287}};
		rf_run <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(FND_REG_FB_INT, 32'((cfg[i][0] << 16) | (cfg[i][1] << 5) | cfg[i][2]));
			// Status shows the ratio in use, so read it after a boundary
			span(1'b1, 2, 0);
			rd(FND_REG_STATUS, d);
			chk({16'h0, d[15:0]}, 32'(cfg[i][3]));
			span(1'b1, 1, 2 * cfg[i][3]);
		end
		span(1'b0, 1, 12);
	endtask

	// Any full modulus run holds exactly numerator overflows
	task automatic t_frac();
		logic [31:0] d;
		wr(FND_REG_FB_INT, 32'h0000_0220);
		wr(FND_REG_FB_FRAC, 32'h0000_0003);
		rd(FND_REG_FB_FRAC, d);
		chk(d, 32'h0000_0003);
		span(1'b1, 2, 0);
		span(1'b1, 16, 2 * (16 * 272 + 3));
		wr(FND_REG_FB_FRAC, 32'h0000_0014);
		span(1'b1, 2, 0);
		span(1'b1, 15, 2 * (15 * 272 + 4));
		wr(FND_REG_FB_FRAC, 32'h0000_001f);
		span(1'b1, 2, 0);
		span(1'b1, 2, 2 * 2 * 273);
		wr(FND_REG_FB_INT, 32'h0001_0420);
		span(1'b1, 2, 0);
		span(1'b1, 1, 2 * 1057);
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_refdiv();
		t_fbint();
		t_frac();
		finish_test();
	end
endmodule
